// *** src/adc_fmt_pkg.sv ***
package adc_fmt_pkg;
  // Sample and result widths
  localparam int SAMPLE_W = 12;
  localparam int RESULT_W = 16;
  // Repeat count select encodings (1, 4, 8, 16 samples)
  localparam logic [1:0] RPT_1 = 2'h0;
  localparam logic [1:0] RPT_4 = 2'h1;
  localparam logic [1:0] RPT_8 = 2'h2;
  localparam logic [1:0] RPT_16 = 2'h3;
  // Justification select values
  localparam logic JUST_RIGHT = 1'h0;
  localparam logic JUST_LEFT = 1'h1;
  // Bit position of the justification select in the control register
  localparam int LJST_BIT = 2;
  // Reset values of the result bytes
  localparam logic [7:0] RESULT_RST = 8'h00;
  // Series lengths as counts
  localparam logic [4:0] LEN_1 = 5'h01;
  localparam logic [4:0] LEN_4 = 5'h04;
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
endpackage

// *** src/sample_accumulator.sv ***
`timescale 1ns/1ps
// Sums a series of samples; reports total and the last-of-series strobe
module sample_accumulator #(
  parameter int SAMPLE_W = 12,
  parameter int SUM_W = 16
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Series control
  input wire logic [4:0] series_len,
  input wire logic abort,
  // Sample stream
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample,
  // Completed series
  output logic sum_valid,
  output logic [SUM_W-1:0] sum
);
  // Sixteen samples need four bits of headroom above one sample
  if (SUM_W < SAMPLE_W + 4)
  begin : g_sum_too_narrow
    $error("SUM_W too small for 16 samples");
  end

  typedef struct packed {
    logic [SUM_W-1:0] acc;
    logic [4:0] count;
    logic done;
    logic [SUM_W-1:0] total;
  } acc_state_t;

  acc_state_t st_reg;
  acc_state_t st_next;

  // Series restarts from zero after each total, so no sample leaks across
  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (abort)
    begin
      st_next.acc = '0;
      st_next.count = 5'h00;
    end
    else if (sample_valid)
    begin
      if (st_reg.count + 5'h01 >= series_len)
      begin
        st_next.total = st_reg.acc + SUM_W'(sample);
        st_next.done = 1'b1;
        st_next.acc = '0;
        st_next.count = 5'h00;
      end
      else
      begin
        st_next.acc = st_reg.acc + SUM_W'(sample);
        st_next.count = st_reg.count + 5'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sum_valid = st_reg.done;
  assign sum = st_reg.total;
endmodule

// *** src/adc_result_formatter.sv ***
`timescale 1ns/1ps
// Function
// - Result split into high and low bytes
// - Repeat one: 12-bit result, update each conversion
// - Repeat one: justify per control register bit two
// - Unused result bits read zero
// - Accumulated result updates after final conversion
// - Accumulate 4, 8 or 16 samples
// - Repeat count from configuration register field
// - Total is plain sum of samples
// - Right-justified: top nibble of high byte zero
// - Left-justified: low nibble of low byte zero

// Data flow: a finished conversion enters the accumulator, which hands on
// a total once the selected number of samples has been summed (one sample
// in single mode). The total is then cut into the two result bytes, and
// the update strobe rises in the same cycle in which the bytes change. Latency
// is two clocks from the taking of the last sample. The justification bit is
// read when the total arrives, so software should not flip it mid-series.
module adc_result_formatter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,

  // Configuration bits from the converter registers
  input wire logic [7:0] converter_control_reg,
  input wire logic [1:0] repeat_count_select,

  // Conversion stream from the converter core
  input wire logic conv_done,
  input wire logic [adc_fmt_pkg::SAMPLE_W-1:0] conv_data,

  // Formatted result bytes
  output logic [7:0] conv_result_high,
  output logic [7:0] conv_result_low,
  output logic result_update
);
  // The byte slicing below is written for a 12-bit sample inside a 16-bit
  // pair; other widths would drop or misplace result bits, so refuse them
  if (adc_fmt_pkg::SAMPLE_W != 12)
  begin : g_bad_sample_w
    $error("SAMPLE_W must be 12 for this formatter");
  end
  if (adc_fmt_pkg::RESULT_W != 16)
  begin : g_bad_result_w
    $error("RESULT_W must be 16 for this formatter");
  end

  // Reset synchroniser; kept apart from the main state because only it is
  // cleared straight from the pin
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
  } rst_state_t;

  // Result bytes, update strobe, and the repeat select seen one cycle ago:
  // it both detects count changes and names the series a total came from
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic upd;
    logic [1:0] rpt_last;
  } fmt_state_t;

  rst_state_t rs_reg;
  rst_state_t rs_next;
  logic rst_n;
  fmt_state_t st_reg;
  fmt_state_t st_next;
  logic [4:0] series_len;
  logic left_justify_select;
  logic sum_valid;
  logic [adc_fmt_pkg::RESULT_W-1:0] sum;
  logic rpt_change;

  // Reset release shifts a one through two flops; only the second is read
  always_comb
  begin
    rs_next.rst_meta = 1'b1;
    rs_next.rst_sync = rs_reg.rst_meta;
  end

  // Assertion stays asynchronous so the outputs clear without a clock;
  // release is synchronous so no flop sees it close to an edge
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rs_reg <= '0;
    else
      rs_reg <= rs_next;
  end
  assign rst_n = rs_reg.rst_sync;

  // Only the justification bit of the control byte is used here
  assign left_justify_select = converter_control_reg[adc_fmt_pkg::LJST_BIT];

  // Series length decode from the repeat field
  // All four codes are legal, so no default is needed
  always_comb
  begin
    unique case (repeat_count_select)
      adc_fmt_pkg::RPT_1: series_len = adc_fmt_pkg::LEN_1;
      adc_fmt_pkg::RPT_4: series_len = adc_fmt_pkg::LEN_4;
      adc_fmt_pkg::RPT_8: series_len = adc_fmt_pkg::LEN_8;
      adc_fmt_pkg::RPT_16: series_len = adc_fmt_pkg::LEN_16;
    endcase
  end

  // Changing the count mid-series would mix lengths, so restart the series
  // The sample taken on the edge of the change is dropped with the rest
  assign rpt_change = repeat_count_select != st_reg.rpt_last;

  // Single conversions run as series of one, so both modes share one path
  // and one two-cycle latency
  sample_accumulator #(
    .SAMPLE_W(adc_fmt_pkg::SAMPLE_W),
    .SUM_W(adc_fmt_pkg::RESULT_W)
  ) i_sample_accumulator (
    .clk(sys_clk),
    .rst_n(rst_n),
    .series_len(series_len),
    .abort(rpt_change),
    .sample_valid(conv_done),
    .sample(conv_data),
    .sum_valid(sum_valid),
    .sum(sum)
  );

  // Format the finished result into the two bytes
  // Totals arriving every cycle keep the strobe high; each cycle is one result
  always_comb
  begin
    st_next = st_reg;
    st_next.upd = 1'b0;
    st_next.rpt_last = repeat_count_select;
    if (sum_valid)
    begin
      st_next.upd = 1'b1;
      // Format follows the length of the series that produced the total, so
      // a count change just after the last sample cannot reshape the result
      unique case (st_reg.rpt_last)
        adc_fmt_pkg::RPT_1:
        begin
          if (left_justify_select == adc_fmt_pkg::JUST_LEFT)
          begin
            // Twelve bits at the top; the low nibble of the low byte is zero
            st_next.high = sum[11:4];
            st_next.low = {sum[3:0], 4'h0};
          end
          else
          begin
            // Twelve bits at the bottom; the top nibble of the high byte is zero
            st_next.high = {4'h0, sum[11:8]};
            st_next.low = sum[7:0];
          end
        end
        adc_fmt_pkg::RPT_4:
        begin
          // Four samples need fourteen bits; the top two read zero
          st_next.high = {2'h0, sum[13:8]};
          st_next.low = sum[7:0];
        end
        adc_fmt_pkg::RPT_8:
        begin
          // Eight samples need fifteen bits; the top one reads zero
          st_next.high = {1'h0, sum[14:8]};
          st_next.low = sum[7:0];
        end
        adc_fmt_pkg::RPT_16:
        begin
          // Sixteen samples fill the pair; the select bit is ignored here
          st_next.high = sum[15:8];
          st_next.low = sum[7:0];
        end
      endcase
    end
  end

  // Result registers; only refreshed at end of conversion or series
  // Between updates the bytes hold, so software may read them at leisure
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg.high <= adc_fmt_pkg::RESULT_RST;
      st_reg.low <= adc_fmt_pkg::RESULT_RST;
      st_reg.upd <= 1'b0;
      st_reg.rpt_last <= adc_fmt_pkg::RPT_1;
    end
    else
      st_reg <= st_next;
  end

  // Outputs come straight from the state flops
  assign conv_result_high = st_reg.high;
  assign conv_result_low = st_reg.low;
  assign result_update = st_reg.upd;
endmodule

// *** verification/fmt_chk_sva.sv ***
`timescale 1ns/1ps
module fmt_chk (
  // Clock, reset and configuration
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] converter_control_reg,
  input wire logic [1:0] repeat_count_select,
  // Sample stream and result
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  input wire logic [7:0] conv_result_high,
  input wire logic [7:0] conv_result_low,
  input wire logic result_update
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  upd_single_a: assert property (conv_done && repeat_count_select == 2'h0 &&
    $stable(repeat_count_select) |-> ##2 result_update) else $error("missing update");
  upd_cause_a: assert property (result_update |-> $past(conv_done, 2)) else $error("stray update");
  hold_bytes_a: assert property (!result_update |-> $stable({conv_result_high, conv_result_low}))
    else $error("result moved");
  right_fmt_a: assert property (result_update && $past(repeat_count_select, 2) == 2'h0 &&
    !$past(converter_control_reg[2], 1) |-> {conv_result_high, conv_result_low} ==
    {4'h0, $past(conv_data, 2)}) else $error("bad right result");
  left_fmt_a: assert property (result_update && $past(repeat_count_select, 2) == 2'h0 &&
    $past(converter_control_reg[2], 1) |-> {conv_result_high, conv_result_low} ==
    {$past(conv_data, 2), 4'h0}) else $error("bad left result");
  acc_four_a: assert property (result_update && $past(repeat_count_select, 2) == 2'h1
    |-> conv_result_high[7:6] == 2'h0) else $error("sum too wide");
  acc_eight_a: assert property (result_update && $past(repeat_count_select, 2) == 2'h2
    |-> !conv_result_high[7]) else $error("sum too wide");
  series_gap_a: assert property (result_update && repeat_count_select == 2'h3 &&
    $past(repeat_count_select, 2) == 2'h3 |=>
    (!result_update || $past(repeat_count_select, 2) != 2'h3) [*8]) else $error("early sum");
endmodule
bind adc_result_formatter fmt_chk i_fmt_chk (.sys_clk, .nrst, .converter_control_reg,
  .repeat_count_select, .conv_done, .conv_data, .conv_result_high, .conv_result_low,
  .result_update);

// *** verification/adc_result_formatter_tb.sv ***
`timescale 1ns/1ps
module adc_result_formatter_tb;
  logic sys_clk = 0, nrst = 0, conv_done = 0, result_update;
  logic [7:0] converter_control_reg = 8'h00, conv_result_high, conv_result_low;
  logic [1:0] repeat_count_select = 2'h0;
  logic [11:0] conv_data = 12'h000, d;
  logic [15:0] sum, exp_v, q[$];
  integer seed = 53, errors = 0, num_checks = 0, cyc = 0, j, k, i, n;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  adc_result_formatter i_adc_result_formatter (.sys_clk, .nrst, .converter_control_reg,
    .repeat_count_select, .conv_done, .conv_data, .conv_result_high, .conv_result_low,
    .result_update);
  task chk(input logic [15:0] s, input logic [15:0] e, input string name);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", name, e, s);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Outputs are looked at mid-cycle, clear of the edge that moves them;
  // each update is matched to the oldest expectation and a hang ends the run
  always @(negedge sys_clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      errors++;
      finish_test;
    end
    else if (result_update === 1'b1)
    begin
      exp_v = q.size() ? q.pop_front() : 16'hxxxx;
      chk({conv_result_high, conv_result_low}, exp_v, "bytes");
    end
  end
  // Back-to-back series per mode; the first series is all full-scale
  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1;
    repeat (3) @(posedge sys_clk);
    for (j = 0; j < 5; j++)
    begin
      repeat_count_select <= j[1:0];
      converter_control_reg <= {5'h00, j == 4, 2'h0};
      n = j % 4 ? 2 << (j % 4) : 1;
      repeat (2) @(posedge sys_clk);
      for (k = 0; k < 3; k++)
      begin
        sum = 16'h0000;
        for (i = 0; i < n; i++)
        begin
          d = k ? 12'($random(seed)) : 12'hfff;
          sum += {4'h0, d};
          @(posedge sys_clk);
          conv_done <= 1;
          conv_data <= d;
        end
        q.push_back(j == 4 ? {d, 4'h0} : sum);
      end
      @(posedge sys_clk);
      conv_done <= 0;
      // Let the last total land before the mode moves on
      repeat (10) @(posedge sys_clk);
    end
    // A partial series of sixteen is cut by a count change; the next total
    // must hold only the four samples that follow it
    repeat_count_select <= 2'h3;
    converter_control_reg <= 8'h00;
    repeat (2) @(posedge sys_clk);
    for (i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      conv_done <= 1;
      conv_data <= 12'hfff;
    end
    @(posedge sys_clk);
    conv_done <= 0;
    repeat_count_select <= 2'h1;
    repeat (2) @(posedge sys_clk);
    sum = 16'h0000;
    for (i = 0; i < 4; i++)
    begin
      d = 12'($random(seed));
      sum += {4'h0, d};
      @(posedge sys_clk);
      conv_done <= 1;
      conv_data <= d;
    end
    q.push_back(sum);
    @(posedge sys_clk);
    conv_done <= 0;
    repeat (4) @(posedge sys_clk);
    chk(16'(q.size()), 16'h0000, "pending");
    finish_test;
  end
endmodule
